/* File: design/cascade_width_sync.sv */
// cascade lane logic: mode roles, lane fifo, wired sync lines, dma pacing
`timescale 1ns/1ps
module cascade_width_sync #(
  parameter int FIFO_DEPTH = cascade_pkg::FIFO_DEPTH_DEF,
  parameter int SKID_DEPTH = cascade_pkg::SKID_DEPTH_DEF
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire cascade_pkg::byte_t reg_wdata_i,
  output cascade_pkg::byte_t reg_rdata_o,
  input wire cascade_pkg::byte_t scsi_data_i,
  input wire logic scsi_parity_i,
  output cascade_pkg::byte_t scsi_data_o,
  output logic scsi_data_oe_n_o,
  input wire logic lane_strobe_i,
  output logic lane_strobe_o,
  output logic lane_strobe_oe_n_o,
  input wire logic bus_lane_sync_n_i,
  output logic bus_lane_sync_n_o,
  output logic bus_lane_sync_oe_n_o,
  input wire logic memory_lane_sync_n_i,
  output logic memory_lane_sync_n_o,
  output logic memory_lane_sync_oe_n_o,
  input wire logic follower_error_n_i,
  output logic follower_error_n_o,
  output logic follower_error_oe_n_o,
  output logic dma_req_n_o,
  input wire logic dma_ack_n_i,
  input wire cascade_pkg::byte_t mem_data_i,
  output cascade_pkg::byte_t mem_data_o,
  output logic mem_data_oe_n_o,
  output logic phase_drive_en_o,
  output logic script_access_en_o,
  output logic [1:0] lane_group_o
);
  import cascade_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int SPW = (SKID_DEPTH > 1) ? $clog2(SKID_DEPTH) : 1;
  localparam int SCW = $clog2(SKID_DEPTH + 1);

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  // ==========================================================
  // pin synchronisers
  pins_t pins_raw;
  pins_t meta_q;
  pins_t sync_q;
  logic stb_d3_q;
  logic ack_d3_q;

  assign pins_raw = '{parity: scsi_parity_i, lane_strobe: lane_strobe_i,
                      bus_sync_n: bus_lane_sync_n_i,
                      mem_sync_n: memory_lane_sync_n_i,
                      error_n: follower_error_n_i, dma_ack_n: dma_ack_n_i,
                      scsi_data: scsi_data_i, mem_data: mem_data_i};

  always_ff @(posedge ref_clk_i) begin
    meta_q <= pins_raw;
    sync_q <= meta_q;
    stb_d3_q <= sync_q.lane_strobe;
    ack_d3_q <= sync_q.dma_ack_n;
  end

  // ==========================================================
  // registers and roles
  mode_t mode_q;
  ctrl_t ctrl_q;
  logic [2:0] sticky_q;

  wire lead_basic = ~mode_q.basic_follower;
  wire lead_bus = ~mode_q.bus_follower;
  wire xfer_en = ctrl_q.xfer_en;
  wire dir_in = ctrl_q.dir_to_mem;
  wire wr_mode = reg_wr_i & hit(reg_addr_i, REG_MODE);
  wire wr_ctrl = reg_wr_i & hit(reg_addr_i, REG_CTRL);
  wire wr_status = reg_wr_i & hit(reg_addr_i, REG_STATUS);
  wire bus_sync_high = sync_q.bus_sync_n;
  wire mem_sync_high = sync_q.mem_sync_n;

  // ==========================================================
  // lane fifo
  byte_t fifo_q [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] cnt_q;
  hs_state_t hs_q;
  hs_state_t hs_d;
  logic [2:0] hs_cnt_q;
  logic [2:0] hs_cnt_d;

  wire fifo_full = (cnt_q == CW'(FIFO_DEPTH));
  wire fifo_empty = (cnt_q == '0);
  wire mem_room = (cnt_q <= CW'(FIFO_DEPTH - SYNC_MARGIN));

  // bus leader starts a handshake only with the wired sync line high
  wire lead_hs_start = lead_bus & xfer_en & (hs_q == HS_IDLE) &
                       bus_sync_high & (dir_in ? ~fifo_full : ~fifo_empty);
  // followers take the leader's strobe on its rising edge
  wire stb_edge = sync_q.lane_strobe & ~stb_d3_q;
  wire lane_evt = lead_bus ? lead_hs_start : (stb_edge & xfer_en);
  wire ack_evt = ~sync_q.dma_ack_n & ack_d3_q & xfer_en;

  wire push_scsi = lane_evt & dir_in & ~fifo_full;
  wire overrun_evt = lane_evt & dir_in & fifo_full;
  wire pop_scsi = lane_evt & ~dir_in & ~fifo_empty;
  wire push_mem = ack_evt & ~dir_in & ~fifo_full;

  // ==========================================================
  // two-entry buffer toward the memory bus
  byte_t skid_q [SKID_DEPTH];
  logic [SPW-1:0] skid_wr_q;
  logic [SPW-1:0] skid_rd_q;
  logic [SCW-1:0] skid_cnt_q;

  wire skid_ready = (skid_cnt_q != SCW'(SKID_DEPTH));
  wire skid_valid = (skid_cnt_q != '0);
  wire fifo_to_skid = dir_in & ~fifo_empty & skid_ready;
  wire skid_pop = ack_evt & dir_in & skid_valid;
  wire underrun_evt = (lane_evt & ~dir_in & fifo_empty) |
                      (ack_evt & dir_in & ~skid_valid);
  wire parity_evt = push_scsi & ~(^{sync_q.scsi_data, sync_q.parity});

  wire fifo_push = push_scsi | push_mem;
  wire fifo_pop = pop_scsi | fifo_to_skid;
  wire [7:0] push_data = dir_in ? sync_q.scsi_data : sync_q.mem_data;
  wire [CW-1:0] cnt_next = cnt_q + CW'(fifo_push) - CW'(fifo_pop);
  wire [SCW-1:0] skid_cnt_next = skid_cnt_q + SCW'(fifo_to_skid) -
                                 SCW'(skid_pop);

  // a buffer pointer wraps at the depth, which need not be a power of two
  wire [SPW-1:0] skid_wr_next = (skid_wr_q == SPW'(SKID_DEPTH - 1)) ?
                                '0 : skid_wr_q + SPW'(1);
  wire [SPW-1:0] skid_rd_next = (skid_rd_q == SPW'(SKID_DEPTH - 1)) ?
                                '0 : skid_rd_q + SPW'(1);
  wire [PW-1:0] wr_ptr_next = (wr_ptr_q == PW'(FIFO_DEPTH - 1)) ?
                              '0 : wr_ptr_q + PW'(1);
  wire [PW-1:0] rd_ptr_next = (rd_ptr_q == PW'(FIFO_DEPTH - 1)) ?
                              '0 : rd_ptr_q + PW'(1);

  always_ff @(posedge ref_clk_i) begin
    if (fifo_push) begin
      fifo_q[wr_ptr_q] <= push_data;
    end
    if (fifo_to_skid) begin
      skid_q[skid_wr_q] <= fifo_q[rd_ptr_q];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i | ~xfer_en) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      skid_wr_q <= '0;
      skid_rd_q <= '0;
      skid_cnt_q <= '0;
    end else begin
      wr_ptr_q <= fifo_push ? wr_ptr_next : wr_ptr_q;
      rd_ptr_q <= fifo_pop ? rd_ptr_next : rd_ptr_q;
      cnt_q <= cnt_next;
      skid_wr_q <= fifo_to_skid ? skid_wr_next : skid_wr_q;
      skid_rd_q <= skid_pop ? skid_rd_next : skid_rd_q;
      skid_cnt_q <= skid_cnt_next;
    end
  end

  // ==========================================================
  // strobe handshake pacing
  always_comb begin
    hs_d = hs_q;
    hs_cnt_d = hs_cnt_q;
    unique case (hs_q)
      HS_IDLE: begin
        if (lead_hs_start) begin
          hs_d = HS_STROBE;
          hs_cnt_d = 3'(STROBE_CYC - 1);
        end
      end
      HS_STROBE: begin
        if (hs_cnt_q == '0) begin
          hs_d = HS_GAP;
          hs_cnt_d = 3'(GAP_CYC - 1);
        end else begin
          hs_cnt_d = hs_cnt_q - 3'(1);
        end
      end
      HS_GAP: begin
        if (hs_cnt_q == '0) begin
          hs_d = HS_IDLE;
        end else begin
          hs_cnt_d = hs_cnt_q - 3'(1);
        end
      end
      default: begin
        hs_d = HS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // dma request pacing
  logic req_q;
  logic [2:0] hold_q;
  wire mem_ready = xfer_en & (dir_in ? skid_valid : mem_room);
  // the hold covers the sync line's trip through the followers' logic
  wire req_set = lead_basic & mem_ready & mem_sync_high & ~req_q &
                 (hold_q == '0) & sync_q.dma_ack_n;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hs_q <= HS_IDLE;
      hs_cnt_q <= '0;
      req_q <= 1'b0;
      hold_q <= '0;
    end else begin
      hs_q <= hs_d;
      hs_cnt_q <= hs_cnt_d;
      // a dropped transfer withdraws its pending request
      req_q <= (req_q & ~ack_evt & lead_basic & xfer_en) | req_set;
      hold_q <= ack_evt ? 3'(HOLD_CYC) :
                (hold_q != '0) ? hold_q - 3'(1) : hold_q;
    end
  end

  // ==========================================================
  // register file
  status_t status_v;
  assign status_v = '{spare: 2'h0, bus_sync_high: bus_sync_high,
                      mem_sync_high: mem_sync_high,
                      follower_err: ~sync_q.error_n,
                      underrun: sticky_q[2], overrun: sticky_q[1],
                      parity_err: sticky_q[0]};
  wire [2:0] sticky_set = {underrun_evt, overrun_evt, parity_evt};
  wire [2:0] sticky_clr = wr_status ? reg_wdata_i[2:0] : 3'h0;
  wire [7:0] rd_mux = hit(reg_addr_i, REG_MODE) ? mode_q :
                      hit(reg_addr_i, REG_CTRL) ? ctrl_q :
                      hit(reg_addr_i, REG_STATUS) ? status_v :
                      hit(reg_addr_i, REG_FIFO_CNT) ? 8'(cnt_q) : 8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mode_q <= MODE_RESET;
      ctrl_q <= CTRL_RESET;
      sticky_q <= STICKY_RESET;
      reg_rdata_o <= 8'h00;
    end else begin
      mode_q <= wr_mode ? reg_wdata_i : mode_q;
      ctrl_q <= wr_ctrl ? reg_wdata_i : ctrl_q;
      // a new event outweighs a clear in the same cycle
      sticky_q <= (sticky_q & ~sticky_clr) | sticky_set;
      reg_rdata_o <= reg_rd_i ? rd_mux : reg_rdata_o;
    end
  end

  // ==========================================================
  // pin drivers
  wire bus_cant = xfer_en ? (dir_in ? fifo_full : fifo_empty) : 1'b1;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      scsi_data_o <= 8'h00;
      scsi_data_oe_n_o <= 1'b1;
      lane_strobe_o <= 1'b0;
      lane_strobe_oe_n_o <= 1'b1;
      bus_lane_sync_n_o <= 1'b0;
      bus_lane_sync_oe_n_o <= 1'b1;
      memory_lane_sync_n_o <= 1'b0;
      memory_lane_sync_oe_n_o <= 1'b1;
      follower_error_n_o <= 1'b0;
      follower_error_oe_n_o <= 1'b1;
      dma_req_n_o <= 1'b1;
      mem_data_o <= 8'h00;
      mem_data_oe_n_o <= 1'b1;
      phase_drive_en_o <= 1'b0;
      script_access_en_o <= 1'b0;
      lane_group_o <= LANE_LOW;
    end else begin
      scsi_data_o <= pop_scsi ? fifo_q[rd_ptr_q] : scsi_data_o;
      scsi_data_oe_n_o <= ~(xfer_en & ~dir_in);
      lane_strobe_o <= (hs_d == HS_STROBE);
      lane_strobe_oe_n_o <= ~lead_bus;
      bus_lane_sync_n_o <= 1'b0;
      bus_lane_sync_oe_n_o <= ~(~lead_bus & bus_cant);
      memory_lane_sync_n_o <= 1'b0;
      // only a basic follower ever pulls the memory sync line
      memory_lane_sync_oe_n_o <= ~(~lead_basic & ~mem_ready);
      follower_error_n_o <= 1'b0;
      follower_error_oe_n_o <= ~(~lead_basic & (|sticky_q));
      dma_req_n_o <= ~((req_q & ~ack_evt & lead_basic & xfer_en) |
                       req_set);
      mem_data_o <= skid_pop ? skid_q[skid_rd_q] : mem_data_o;
      mem_data_oe_n_o <= ~(dir_in & xfer_en & ~sync_q.dma_ack_n);
      // phases and scripts stay with the chip leading in both modes
      phase_drive_en_o <= lead_basic & lead_bus;
      script_access_en_o <= lead_basic & lead_bus;
      lane_group_o <= lead_basic ? LANE_LOW :
                      lead_bus ? LANE_MID : LANE_HIGH;
    end
  end

endmodule

/* File: design/cascade_pkg.sv */
// constants, register layouts and carrier types of the cascade lane logic
package cascade_pkg;

  // ==========================================================
  // register offsets
  localparam logic [4:0] REG_MODE = 5'h07;
  localparam logic [4:0] REG_FIFO_CNT = 5'h1D;
  localparam logic [4:0] REG_CTRL = 5'h1E;
  localparam logic [4:0] REG_STATUS = 5'h1F;

  // ==========================================================
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] STICKY_RESET = 3'h0;

  // ==========================================================
  // sizes and timing
  localparam int FIFO_DEPTH_DEF = 64;
  localparam int SKID_DEPTH_DEF = 2;
  localparam int SYNC_MARGIN = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 40;
  localparam int GAP_NS = 40;
  localparam int HOLD_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] LANE_LOW = 2'h0;
  localparam logic [1:0] LANE_MID = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;

  // ==========================================================
  // carriers
  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic basic_follower;
    logic bus_follower;
    logic [5:0] spare;
  } mode_t;

  typedef struct packed {
    logic [5:0] spare;
    logic dir_to_mem;
    logic xfer_en;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] spare;
    logic bus_sync_high;
    logic mem_sync_high;
    logic follower_err;
    logic underrun;
    logic overrun;
    logic parity_err;
  } status_t;

  typedef struct packed {
    logic parity;
    logic lane_strobe;
    logic bus_sync_n;
    logic mem_sync_n;
    logic error_n;
    logic dma_ack_n;
    byte_t scsi_data;
    byte_t mem_data;
  } pins_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_STROBE = 2'b01,
    HS_GAP = 2'b10
  } hs_state_t;

endpackage

/* File: tb/cascade_width_sync_asserts.sv */
// concurrent checks on the cascade lane ports
`timescale 1ns/1ps
module cascade_width_sync_asserts
  import cascade_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic lane_strobe_o,
  input wire logic lane_strobe_oe_n_o,
  input wire logic bus_lane_sync_n_i,
  input wire logic memory_lane_sync_n_i,
  input wire logic dma_req_n_o,
  input wire logic dma_ack_n_i,
  input wire logic mem_data_oe_n_o,
  input wire logic phase_drive_en_o,
  input wire logic script_access_en_o,
  input wire logic [1:0] lane_group_o
);
  // ==========
  // frame
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence strobe_high;
    lane_strobe_o [*4];
  endsequence
  sequence strobe_low;
    !lane_strobe_o [*4];
  endsequence
  // ==========
  // roles
  a_req_leader_only: assert property (
    lane_group_o != LANE_LOW && $past(lane_group_o) != LANE_LOW
    |-> dma_req_n_o)
    else $error("dma request from a follower");
  a_follower_no_phase: assert property (
    lane_group_o != LANE_LOW |-> !phase_drive_en_o && !script_access_en_o)
    else $error("follower drives phases or script memory");
  a_bus_follower_quiet: assert property (
    lane_group_o == LANE_HIGH |-> lane_strobe_oe_n_o)
    else $error("bus follower drives the strobe");
  a_mid_lane_paces: assert property (
    lane_group_o == LANE_MID && $past(lane_group_o) == LANE_MID
    |-> !lane_strobe_oe_n_o)
    else $error("mid lane chip does not drive the strobe");
  // ==========
  // handshakes; sync inputs pass two flops, so look back three or four
  a_strobe_shape: assert property (
    $rose(lane_strobe_o) |-> strobe_high ##1 strobe_low)
    else $error("strobe pulse or gap length wrong");
  a_strobe_needs_sync: assert property (
    $rose(lane_strobe_o)
    |-> $past(bus_lane_sync_n_i, 3) || $past(bus_lane_sync_n_i, 4))
    else $error("strobe while bus sync was low");
  a_req_needs_sync: assert property (
    $fell(dma_req_n_o)
    |-> $past(memory_lane_sync_n_i, 3) || $past(memory_lane_sync_n_i, 4))
    else $error("request while memory sync was low");
  a_lane_on_grant: assert property (
    !mem_data_oe_n_o |-> !$past(dma_ack_n_i, 3) || !$past(dma_ack_n_i, 4))
    else $error("memory lane driven without grant");
endmodule

/* File: tb/dma_partner.sv */
// dma controller model granting the shared request line
`timescale 1ns/1ps
module dma_partner (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_n_i,
  input wire logic slow_i,
  input wire logic [7:0] word_i,
  output logic ack_n_o,
  output logic [7:0] data_o
);
  int wait_q;
  // ==========
  // grant after a short or long wait, drop once the request goes away
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_n_o <= 1'b1;
      wait_q <= 0;
    end else if (ack_n_o && !req_n_i) begin
      wait_q <= wait_q + 1;
      if (wait_q >= (slow_i ? 6 : 1)) begin
        ack_n_o <= 1'b0;
      end
    end else if (!ack_n_o && req_n_i) begin
      ack_n_o <= 1'b1;
      wait_q <= 0;
    end
  end
  // released bus shows the inverse so a stale word never passes
  assign data_o = ack_n_o ? ~word_i : word_i;
endmodule

/* File: tb/tb_cascade_width_sync.sv */
// self-checking bench for the cascade lane logic
`timescale 1ns/1ps
module tb_cascade_width_sync;
  import cascade_pkg::*;
  localparam int FIFO_DEPTH = FIFO_DEPTH_DEF;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [4:0] reg_addr_i = 5'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  byte_t reg_wdata_i = 8'h00;
  byte_t scsi_data_i = 8'h00;
  logic scsi_parity_i = 1'b0;
  logic strb = 1'b0;
  logic ext_bus_n = 1'b1;
  logic ext_mem_n = 1'b1;
  logic kick_n = 1'b1;
  logic slow = 1'b0;
  logic seen;
  byte_t word = 8'h00;
  byte_t reg_rdata_o, scsi_data_o, mem_data_o, mem_data_i;
  logic scsi_data_oe_n_o, lane_strobe_o, lane_strobe_oe_n_o;
  logic bus_lane_sync_n_o, bus_lane_sync_oe_n_o, memory_lane_sync_n_o;
  logic memory_lane_sync_oe_n_o, follower_error_n_o, follower_error_oe_n_o;
  logic dma_req_n_o, dma_ack_n_i, mem_data_oe_n_o;
  logic phase_drive_en_o, script_access_en_o;
  logic [1:0] lane_group_o;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  byte_t modes[3] = '{8'h00, 8'h8A, 8'hC5};
  logic [1:0] grp[3] = '{LANE_LOW, LANE_MID, LANE_HIGH};
  // ==========
  // wired lines; sync, error and request lines pulled high when nobody pulls, the strobe low
  wire logic lane_strobe_i = strb | (!lane_strobe_oe_n_o & lane_strobe_o);
  wire logic bus_lane_sync_n_i = bus_lane_sync_oe_n_o & ext_bus_n;
  wire logic memory_lane_sync_n_i = memory_lane_sync_oe_n_o & ext_mem_n;
  wire logic follower_error_n_i = follower_error_oe_n_o;
  wire logic req_line_n = dma_req_n_o & kick_n;
  cascade_width_sync #(.FIFO_DEPTH(FIFO_DEPTH), .SKID_DEPTH(SKID_DEPTH_DEF)) uut (
    .ref_clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .scsi_data_i, .scsi_parity_i, .scsi_data_o,
    .scsi_data_oe_n_o, .lane_strobe_i, .lane_strobe_o, .lane_strobe_oe_n_o,
    .bus_lane_sync_n_i, .bus_lane_sync_n_o, .bus_lane_sync_oe_n_o,
    .memory_lane_sync_n_i, .memory_lane_sync_n_o, .memory_lane_sync_oe_n_o,
    .follower_error_n_i, .follower_error_n_o, .follower_error_oe_n_o,
    .dma_req_n_o, .dma_ack_n_i, .mem_data_i, .mem_data_o, .mem_data_oe_n_o,
    .phase_drive_en_o, .script_access_en_o, .lane_group_o);
  dma_partner dma (.clk_i(ref_clk_i), .reset_i(reset_i), .req_n_i(req_line_n),
    .slow_i(slow), .word_i(word), .ack_n_o(dma_ack_n_i), .data_o(mem_data_i));
  always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
  // ==========
  // tasks
  task automatic summarize;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input byte_t d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input byte_t exp, input string nm);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(nm, reg_rdata_o, exp);
  endtask
  task automatic watch(output logic s);
    s = 1'b0;
    repeat (16) begin
      @(negedge ref_clk_i);
      s = s | lane_strobe_o;
    end
  endtask
  task automatic pulse;
    @(posedge ref_clk_i);
    strb <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    strb <= 1'b0;
    repeat (6) @(negedge ref_clk_i);
  endtask
  // fill of the whole fifo dominates; ceiling well above it
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      summarize();
    end
  end
  // ==========
  // sequence
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd_chk(REG_MODE, MODE_RESET, "mode");
    rd_chk(REG_CTRL, CTRL_RESET, "ctrl");
    rd_chk(5'h10, 8'h00, "unmapped");
    // bit 6 is never set without bit 7
    foreach (modes[i]) begin
      wr(REG_MODE, modes[i]);
      rd_chk(REG_MODE, modes[i], "mode");
      chk("phase", phase_drive_en_o, i == 0);
      chk("script", script_access_en_o, i == 0);
      chk("group", lane_group_o, grp[i]);
      chk("strobe oe", lane_strobe_oe_n_o, i == 2);
      chk("req", dma_req_n_o, 1'b1);
    end
    // leader set up first, follower last
    wr(REG_MODE, 8'h00);
    @(posedge ref_clk_i);
    ext_mem_n <= 1'b0;
    scsi_data_i <= 8'h3C;
    scsi_parity_i <= 1'b1;
    slow <= 1'b1;
    wr(REG_CTRL, 8'h03);
    watch(seen);
    chk("strobing", seen, 1'b1);
    repeat (600) @(negedge ref_clk_i);
    chk("req held", dma_req_n_o, 1'b1);
    rd_chk(REG_FIFO_CNT, 8'(FIFO_DEPTH), "fifo count");
    watch(seen);
    chk("full strobe", seen, 1'b0);
    @(posedge ref_clk_i);
    ext_mem_n <= 1'b1;
    for (int i = 0; i < 40 && dma_req_n_o !== 1'b0; i++)
      @(negedge ref_clk_i);
    chk("req", dma_req_n_o, 1'b0);
    for (int i = 0; i < 40 && mem_data_oe_n_o !== 1'b0; i++)
      @(negedge ref_clk_i);
    chk("mem lane", mem_data_o, 8'h3C);
    @(posedge ref_clk_i);
    ext_bus_n <= 1'b0;
    repeat (12) @(negedge ref_clk_i);
    watch(seen);
    chk("stalled strobe", seen, 1'b0);
    wr(REG_CTRL, 8'h00);
    repeat (20) @(posedge ref_clk_i);
    ext_bus_n <= 1'b1;
    slow <= 1'b0;
    word <= 8'hA5;
    wr(REG_STATUS, 8'h07);
    wr(REG_MODE, 8'hC0);
    wr(REG_CTRL, 8'h01);
    repeat (6) @(negedge ref_clk_i);
    chk("bus sync oe", bus_lane_sync_oe_n_o, 1'b0);
    chk("mem sync oe", memory_lane_sync_oe_n_o, 1'b1);
    chk("scsi oe", scsi_data_oe_n_o, 1'b0);
    @(posedge ref_clk_i);
    kick_n <= 1'b0;
    for (int i = 0; i < 40 && dma_ack_n_i !== 1'b0; i++)
      @(negedge ref_clk_i);
    repeat (5) @(posedge ref_clk_i);
    kick_n <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd_chk(REG_FIFO_CNT, 8'h01, "fifo count");
    chk("follower req", dma_req_n_o, 1'b1);
    chk("bus sync oe", bus_lane_sync_oe_n_o, 1'b1);
    pulse();
    chk("bus lane", scsi_data_o, 8'hA5);
    pulse();
    chk("error oe", follower_error_oe_n_o, 1'b0);
    rd_chk(REG_STATUS, 8'h1C, "status");
    wr(REG_STATUS, 8'h04);
    repeat (6) @(posedge ref_clk_i);
    rd_chk(REG_STATUS, 8'h10, "status");
    chk("error oe", follower_error_oe_n_o, 1'b1);
    summarize();
  end
endmodule
bind cascade_width_sync cascade_width_sync_asserts #(
  .FIFO_DEPTH(FIFO_DEPTH)
) checks (
  .ref_clk_i, .reset_i, .lane_strobe_o, .lane_strobe_oe_n_o,
  .bus_lane_sync_n_i, .memory_lane_sync_n_i, .dma_req_n_o, .dma_ack_n_i,
  .mem_data_oe_n_o, .phase_drive_en_o, .script_access_en_o, .lane_group_o);
